// [hdl/asrp_pkg.sv]
// constants and types for the serial readout port
`default_nettype none
package asrp_pkg;
   localparam int FRAME_BITS = 32;
   localparam int CFG_BITS = 8;
   localparam int CNT_W = 6;
   localparam int RESULT_BITS = 24;
   localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
   localparam logic [CNT_W-1:0] CNT_CFG_DONE = 6'h08;
   localparam logic [CNT_W-1:0] CNT_LAST = 6'h1f;
   localparam logic [1:0] ECHO_TOP = 2'h0;
   localparam logic [1:0] CFG_TOP = 2'h2;
   localparam logic [7:0] CFG_RESET = 8'h00;

   // channel configuration fields
   typedef struct packed {
      logic [1:0] top;
      logic update_en;
      logic single_ended_select;
      logic odd_sign;
      logic [2:0] addr;
   } asrp_cfg_s;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SHIFT, ST_DONE} asrp_state_e;
endpackage
`default_nettype wire

// [hdl/asrp_port.sv]
// device side serial readout port
`default_nettype none
module asrp_port (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   input wire logic conv_done_i,
   input wire logic [asrp_pkg::RESULT_BITS-1:0] result_i,
   output logic conv_start_o,
   output asrp_pkg::asrp_cfg_s cfg_o,
   output logic cfg_valid_o
);
   logic [1:0] cs_sync;
   logic [1:0] sck_sync;
   logic [1:0] sdi_sync;
   logic sck_prev;
   logic [asrp_pkg::CNT_W-1:0] bit_cnt;
   logic [asrp_pkg::FRAME_BITS-1:0] shreg;
   logic [asrp_pkg::CFG_BITS-1:0] cfg_in;
   asrp_pkg::asrp_cfg_s cur_cfg;
   asrp_pkg::asrp_state_e state;
   logic cs_n;
   logic sck_rise;
   logic sck_fall;
   localparam int TAIL_BITS = asrp_pkg::FRAME_BITS - 2 - asrp_pkg::CFG_BITS;
   logic [TAIL_BITS-1:0] result_top;
   logic frame_msb;

   assign cs_n = cs_sync[1];
   assign sck_rise = sck_sync[1] & ~sck_prev;
   assign sck_fall = ~sck_sync[1] & sck_prev;
   // only the upper result bits fit behind the two lead bits and the echo byte
   assign result_top = result_i[asrp_pkg::RESULT_BITS-1 -: TAIL_BITS];
   assign frame_msb = shreg[asrp_pkg::FRAME_BITS-1];

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cs_sync <= 2'h3;
         sck_sync <= 2'h0;
         sdi_sync <= 2'h0;
         sck_prev <= 1'b0;
      end else begin
         cs_sync <= {cs_sync[0], cs_n_i};
         sck_sync <= {sck_sync[0], sck_i};
         sdi_sync <= {sdi_sync[0], sdi_i};
         sck_prev <= sck_sync[1];
      end
   end

   // frame sequencing
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state <= asrp_pkg::ST_IDLE;
         bit_cnt <= asrp_pkg::CNT_ZERO;
      end else if (cs_n) begin
         state <= asrp_pkg::ST_IDLE;
         bit_cnt <= asrp_pkg::CNT_ZERO;
      end else begin
         case (state)
            asrp_pkg::ST_IDLE: state <= asrp_pkg::ST_WAIT;
            asrp_pkg::ST_WAIT: if (conv_done_i && !sck_sync[1]) state <= asrp_pkg::ST_SHIFT;
            asrp_pkg::ST_SHIFT: begin
               if (sck_rise) begin
                  bit_cnt <= bit_cnt + asrp_pkg::CNT_ONE;
                  if (bit_cnt == asrp_pkg::CNT_LAST) state <= asrp_pkg::ST_DONE;
               end
            end
            asrp_pkg::ST_DONE: state <= asrp_pkg::ST_DONE;
            default: state <= asrp_pkg::ST_IDLE;
         endcase
      end
   end

   // output shift register: done bit, filler_bit, echo, result
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         shreg <= '0;
      end else if (state == asrp_pkg::ST_WAIT) begin
         shreg <= {1'b0, 1'b0, asrp_pkg::ECHO_TOP, cur_cfg[5:0], result_top};
      end else if (state == asrp_pkg::ST_SHIFT && sck_fall) begin
         shreg <= {shreg[asrp_pkg::FRAME_BITS-2:0], 1'b0};
      end
   end

   // sdo: busy high, done low, then frame bits
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sdo_o <= 1'b1;
         sdo_oe_o <= 1'b0;
      end else begin
         sdo_oe_o <= ~cs_n;
         case (state)
            asrp_pkg::ST_WAIT: sdo_o <= ~conv_done_i;
            asrp_pkg::ST_SHIFT: sdo_o <= shreg[asrp_pkg::FRAME_BITS-1];
            asrp_pkg::ST_DONE: sdo_o <= 1'b0;
            default: sdo_o <= 1'b1;
         endcase
      end
   end

   // config byte capture, msb first
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cfg_in <= asrp_pkg::CFG_RESET;
         cur_cfg <= asrp_pkg::CFG_RESET;
         cfg_o <= asrp_pkg::CFG_RESET;
         cfg_valid_o <= 1'b0;
      end else begin
         cfg_valid_o <= 1'b0;
         if (state == asrp_pkg::ST_SHIFT && sck_rise && bit_cnt < asrp_pkg::CNT_CFG_DONE)
            cfg_in <= {cfg_in[asrp_pkg::CFG_BITS-2:0], sdi_sync[1]};
         if (state == asrp_pkg::ST_SHIFT && sck_fall && bit_cnt == asrp_pkg::CNT_CFG_DONE) begin
            if (cfg_in[7:6] == asrp_pkg::CFG_TOP && cfg_in[5]) begin
               cur_cfg <= cfg_in;
               cfg_o <= cfg_in;
               cfg_valid_o <= 1'b1;
            end
         end
      end
   end

   // a conversion restarts when cs rises after a frame
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) conv_start_o <= 1'b0;
      else conv_start_o <= cs_n && state == asrp_pkg::ST_DONE;
   end

   a_busy_high: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == asrp_pkg::ST_WAIT && !cs_n |=> sdo_o == !$past(conv_done_i))
      else $error("sdo does not track conversion state");
   a_cs_ends: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cs_n |=> state == asrp_pkg::ST_IDLE && !sdo_oe_o)
      else $error("cs high did not end output");
   a_frame_len: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == asrp_pkg::ST_SHIFT && sck_rise && bit_cnt == asrp_pkg::CNT_LAST && !cs_n
      |=> state == asrp_pkg::ST_DONE)
      else $error("frame did not end after 32 bits");
   a_echo_top: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == asrp_pkg::ST_WAIT && !cs_n |=> shreg[29:28] == asrp_pkg::ECHO_TOP)
      else $error("echo top bits not zero");
   a_lead_bits: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == asrp_pkg::ST_WAIT && !cs_n |=> shreg[31:30] == 2'h0)
      else $error("leading bits not low");
   a_cfg_update: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cfg_valid_o |-> cfg_o.top == asrp_pkg::CFG_TOP && cfg_o.update_en)
      else $error("bad config accepted");

   a_idle_to_wait: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == asrp_pkg::ST_IDLE && !cs_n
      |=> state == asrp_pkg::ST_WAIT)
      else $error("select did not start waiting");

   a_wait_to_shift: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == asrp_pkg::ST_WAIT && !cs_n && conv_done_i && !sck_sync[1]
      |=> state == asrp_pkg::ST_SHIFT)
      else $error("finished conversion did not open the frame");

   a_wait_holds: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == asrp_pkg::ST_WAIT && !cs_n && !conv_done_i
      |=> state == asrp_pkg::ST_WAIT)
      else $error("frame opened during conversion");

   a_oe_follows: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !cs_n
      |=> sdo_oe_o)
      else $error("sdo not driven while selected");

   a_sdo_idle_high: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cs_n ##1 cs_n
      |=> sdo_o)
      else $error("sdo not high while deselected");

   a_sdo_frame_bit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == asrp_pkg::ST_SHIFT && !cs_n
      |=> sdo_o == $past(frame_msb))
      else $error("sdo does not show the frame bit");

   a_done_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == asrp_pkg::ST_DONE && !cs_n
      |=> !sdo_o)
      else $error("sdo not low after the frame");

   a_cnt_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == asrp_pkg::ST_SHIFT && !sck_rise && !cs_n
      |=> $stable(bit_cnt))
      else $error("bit count moved without a clock");

   a_cnt_step: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == asrp_pkg::ST_SHIFT && sck_rise && !cs_n
      |=> bit_cnt == $past(bit_cnt) + asrp_pkg::CNT_ONE)
      else $error("bit count did not step");

   a_cs_clears_cnt: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cs_n
      |=> bit_cnt == asrp_pkg::CNT_ZERO)
      else $error("bit count kept across deselect");

   a_cfg_window: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cfg_valid_o
      |-> $past(bit_cnt) == asrp_pkg::CNT_CFG_DONE)
      else $error("config taken outside its window");

   a_cfg_refused: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == asrp_pkg::ST_SHIFT && sck_fall && !cs_n && bit_cnt == asrp_pkg::CNT_CFG_DONE
      && !(cfg_in[7:6] == asrp_pkg::CFG_TOP && cfg_in[5]) |=> $stable(cur_cfg) && !cfg_valid_o)
      else $error("refused config was applied");

   a_cfg_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cfg_valid_o
      |=> !cfg_valid_o)
      else $error("config valid longer than one cycle");

   a_echo_body: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == asrp_pkg::ST_WAIT && !cs_n
      |=> shreg[TAIL_BITS +: 6] == cur_cfg[5:0])
      else $error("echo byte does not hold the config");

   a_result_tail: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state == asrp_pkg::ST_WAIT && !cs_n
      |=> shreg[TAIL_BITS-1:0] == $past(result_top))
      else $error("result bits not loaded");

   a_start_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      conv_start_o
      |=> !conv_start_o)
      else $error("conversion start longer than one cycle");
endmodule // asrp_port
`default_nettype wire

// [test/asrp_ctrl_model.sv]
// controller model driving the serial readout port
`default_nettype none
module asrp_ctrl_model (
   output logic cs_n_o = 1'b1,
   output logic sck_o = 1'b0,
   output logic sdi_o = 1'b0,
   input wire logic sdo_i
);
   timeunit 1ns;
   timeprecision 100ps;
   task automatic select;
      cs_n_o = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] c, output logic [31:0] f, output logic ok);
      int n;
      n = 0;
      while (sdo_i !== 1'b0 && n < 400) begin
         #10;
         n++;
      end
      ok = n < 400;
      for (int i = 31; i >= 0; i--) begin
         sdi_o = (i > 23) ? c[i-24] : ~sdi_o;
         #48 f[i] = sdo_i;
         #2 sck_o = 1'b1;
         #30 sck_o = 1'b0;
      end
      #20 cs_n_o = 1'b1;
   endtask
endmodule // asrp_ctrl_model
`default_nettype wire

// [test/asrp_port_tb.sv]
// bench for the serial readout port
`default_nettype none
module asrp_port_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, conv_done_i = 1'b0, ok, cs_n, sck, sdi, sdo, oe, st, cv;
   logic [23:0] result_i = 24'h00_0000;
   logic [31:0] f, seed = 32'h69b6_df51;
   logic [7:0] c, acc = 8'h00;
   asrp_pkg::asrp_cfg_s cfg;
   int err_total = 0, checks_done = 0, n, cv_seen = 0, cv_want = 0;
   initial forever #5 ref_clk_i = ~ref_clk_i;
   always @(negedge ref_clk_i) if (cv === 1'b1) cv_seen++;
   asrp_port u_asrp_port (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck),
      .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(oe), .conv_done_i(conv_done_i), .result_i(result_i),
      .conv_start_o(st), .cfg_o(cfg), .cfg_valid_o(cv));
   asrp_ctrl_model u_asrp_ctrl_model (.cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi), .sdo_i(sdo));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude;
      if (err_total == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #200_000;
      err_total++;
      conclude();
   end
   initial begin
      repeat (12) @(posedge ref_clk_i);
      #1 rst_i = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      chk("cfg_o", 32'h0, cfg);
      for (int k = 0; k < 12; k++) begin
         seed = xs(seed);
         c = k == 0 ? 8'hbf : k == 1 ? 8'h3f : k == 2 ? 8'h9f :
            {seed[9] ? 2'h2 : seed[7:6], seed[5:0]};
         @(posedge ref_clk_i);
         #1 conv_done_i = 1'b0;
         result_i = seed[31:8];
         u_asrp_ctrl_model.select();
         repeat (10) @(negedge ref_clk_i);
         chk("sdo_o", 32'h1, sdo);
         chk("sdo_oe_o", 32'h1, oe);
         @(posedge ref_clk_i);
         #1 conv_done_i = 1'b1;
         u_asrp_ctrl_model.xfer(c, f, ok);
         chk("done seen", 32'h1, ok);
         chk("lead bits", 32'h0, f[31:30]);
         chk("echo", {2'h0, acc[5:0]}, f[29:22]);
         chk("result", {10'h000, seed[31:10]}, {10'h000, f[21:0]});
         if (c[7:6] == 2'h2 && c[5]) begin
            acc = c;
            cv_want++;
         end
         n = 0;
         while (st !== 1'b1 && n < 20) begin
            @(negedge ref_clk_i);
            n++;
         end
         chk("conv_start_o", 32'h1, st);
         chk("sdo_oe_o", 32'h0, oe);
         chk("cfg_o", acc[5:0], cfg[5:0]);
      end
      chk("cfg_valid_o", cv_want, cv_seen);
      conclude();
   end
endmodule // asrp_port_tb
`default_nettype wire
